// file: logic/timer16_defs.svh
// constants of the byte-access 16-bit timer: map, fields, limits
`ifndef TIMER16_DEFS_SVH
`define TIMER16_DEFS_SVH
// apb address width and word-aligned register map
`define ADDR_W      8
`define A_CNT_LO    8'h00
`define A_CNT_HI    8'h04
`define A_CMPA_LO   8'h08
`define A_CMPA_HI   8'h0C
`define A_CMPB_LO   8'h10
`define A_CMPB_HI   8'h14
`define A_CAP_LO    8'h18
`define A_CAP_HI    8'h1C
`define A_CTRL_A    8'h20
`define A_CTRL_B    8'h24
`define A_FLAG      8'h28
`define A_MASK      8'h2C
`define A_PWR       8'h30
// count limits
`define BOTTOM_VAL  16'h0000
`define MAX_VAL     16'hFFFF
`define TOP_8B      16'h00FF
`define TOP_9B      16'h01FF
`define TOP_10B     16'h03FF
// control a fields
`define WGML_LSB    0
`define CAP_SRC_BIT 2
`define COMB_LSB    4
`define COMA_LSB    6
// control b fields
`define CS_LSB      0
`define WGMH_LSB    3
`define CAP_EDG_BIT 6
`define CAP_FLT_BIT 7
// flag and mask bit positions
`define F_OVF       0
`define F_CMPA      1
`define F_CMPB      2
`define F_CAP       3
// reset values
`define CTRL_RST    8'h00
`define PWR_RST     1'b1
// prescaler width and tap widths
`define PSC_W       10
`define TAP8_W      3
`define TAP64_W     6
`define TAP256_W    8
`define TAP1024_W   10
// capture filter sample count
`define FILT_LEN    4
`endif

// file: logic/timer16_pkg.sv
// types shared by the byte-access 16-bit timer
package timer16_pkg;
	typedef enum logic [2:0] {
		CS_STOP     = 3'h0,
		CS_DIV1     = 3'h1,
		CS_DIV8     = 3'h2,
		CS_DIV64    = 3'h3,
		CS_DIV256   = 3'h4,
		CS_DIV1024  = 3'h5,
		CS_EXT_FALL = 3'h6,
		CS_EXT_RISE = 3'h7
	} clk_sel_e;
	typedef logic [15:0] word_t;
	typedef logic [7:0]  byte_t;
	typedef logic [3:0]  mode_t;
endpackage

// file: logic/timer16_core.sv
// byte-access 16-bit timer/counter core behind an apb slave
// Operation
// - wide registers reached as two byte transfers
// - one shared high-byte staging register
// - low-byte write loads staged high plus low
// - count/capture low-byte read copies high into staging
// - compare high reads bypass the staging register
// - control registers plain byte read/write
// - tick from prescaler or external pin edge
// - no clock source selected: counter holds
// - compare registers checked against count always
// - compare outputs give pwm or frequency waveform
// - compare match sets compare flag a/b
// - capture edge stores count in capture register unless it is top
// - selectable noise filter on capture trigger
// - counter spans 0x0000 up to 0xFFFF
// - top from fixed limits, compare a, capture
// - compare a as top drives no pwm
// - compare a top is double buffered in pwm modes
// - four flags, each maskable
// - software count write beats count/clear
// - capture flag set with capture copy
//
// The implementer's own choices: the APB register port and the register addresses.
`include "timer16_defs.svh"
module timer16_core
	import timer16_pkg::*;
#(
	parameter int FILT_LEN = `FILT_LEN
) (
	input  wire logic              i_clk,      // system clock, 40 MHz
	input  wire logic              i_rstn,     // async reset, active low
	input  wire logic              i_psel,     // apb select
	input  wire logic              i_penable,  // apb access phase
	input  wire logic              i_pwrite,   // apb direction
	input  wire logic [`ADDR_W-1:0] i_paddr,   // apb byte address
	input  wire logic [31:0]       i_pwdata,   // apb write data
	input  wire logic [3:0]        i_pstrb,    // apb byte strobes
	output logic                   o_pready,   // apb ready
	output logic [31:0]            o_prdata,   // apb read data
	output logic                   o_pslverr,  // unmapped address
	input  wire logic              i_external_count_pin, // count pin
	input  wire logic              i_capture_pin,        // capture pin
	input  wire logic              i_acomp_out,          // comparator
	output logic                   o_compare_a_output,   // wave a
	output logic                   o_compare_b_output,   // wave b
	output logic [3:0]             o_int_req             // masked flags
);

	byte_t        temp_reg;      // shared high-byte staging
	byte_t        snap_hi_reg;   // high byte frozen at setup
	word_t        count_value_reg;
	word_t        capture_value_reg;
	word_t        cmp_buf_reg [2];
	word_t        cmp_act_reg [2];
	logic [1:0]   cmp_out_reg;
	byte_t        timer_control_a_reg;
	byte_t        timer_control_b_reg;
	logic [3:0]   timer_flag_register_reg;
	logic [3:0]   timer_mask_register_reg;
	logic         pwr_reg;       // timer_power_reduction_bit
	logic [`PSC_W-1:0] psc_reg;
	logic         ext_s1_reg, ext_s2_reg, ext_d_reg;
	logic         cap_s1_reg, cap_s2_reg, ac_s1_reg, ac_s2_reg;
	logic [FILT_LEN-1:0] hist_reg;
	logic         filt_reg, filt_d_reg;

	logic         setup, acc, wr, rd, cnt_wr, timer_tick, cap_evt;
	logic         pwm, at_top, wrap, ovf_evt, cap_top, a_top, trig;
	logic [1:0]   match, cmp_evt;
	mode_t        mode;
	clk_sel_e     cs;
	word_t        top, wdata16;
	byte_t        rd_mux, hi_mux;
	logic [3:0]   flag_set, flag_clr;

	// apb phases; a write needs the low byte lane
	assign setup   = i_psel & ~i_penable;
	assign acc     = i_psel & i_penable & o_pready;
	assign wr      = acc & i_pwrite & i_pstrb[0];
	assign rd      = acc & ~i_pwrite;
	assign wdata16 = {temp_reg, i_pwdata[7:0]};
	assign cnt_wr  = wr & (i_paddr == `A_CNT_LO);

	// mode decode shared by top, buffering and waveform
	assign mode = {timer_control_b_reg[`WGMH_LSB +: 2],
		timer_control_a_reg[`WGML_LSB +: 2]};
	assign cs   = clk_sel_e'(timer_control_b_reg[`CS_LSB +: 3]);

	// top of the count sequence for a waveform mode
	function automatic word_t top_of(input mode_t m, input word_t a,
		input word_t c);
		case (m)
			4'h1, 4'h5: top_of = `TOP_8B;
			4'h2, 4'h6: top_of = `TOP_9B;
			4'h3, 4'h7: top_of = `TOP_10B;
			4'h4, 4'h9, 4'hB, 4'hF: top_of = a;
			4'h8, 4'hA, 4'hC, 4'hE: top_of = c;
			default: top_of = `MAX_VAL;
		endcase
	endfunction

	// pulse-width modes; the rest count as normal or ctc
	function automatic logic is_pwm(input mode_t m);
		case (m)
			4'h0, 4'h4, 4'hC, 4'hD: is_pwm = 1'b0;
			default: is_pwm = 1'b1;
		endcase
	endfunction

	// address check for the slave error answer
	function automatic logic mapped(input logic [`ADDR_W-1:0] a);
		case (a)
			`A_CNT_LO, `A_CNT_HI, `A_CMPA_LO, `A_CMPA_HI, `A_CMPB_LO,
			`A_CMPB_HI, `A_CAP_LO, `A_CAP_HI, `A_CTRL_A, `A_CTRL_B,
			`A_FLAG, `A_MASK, `A_PWR: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	endfunction

	// high-byte locations all land in the one staging register
	function automatic logic is_hi(input logic [`ADDR_W-1:0] a);
		is_hi = (a == `A_CNT_HI) || (a == `A_CMPA_HI) ||
			(a == `A_CMPB_HI) || (a == `A_CAP_HI);
	endfunction

	assign pwm     = is_pwm(mode);
	assign top     = top_of(mode, cmp_act_reg[0], capture_value_reg);
	assign cap_top = (mode == 4'h8) || (mode == 4'hA) ||
		(mode == 4'hC) || (mode == 4'hE);
	assign a_top   = (mode == 4'h9) || (mode == 4'hB) || (mode == 4'hF);
	assign at_top  = (count_value_reg == top);
	assign wrap    = timer_tick & ~cnt_wr & at_top;
	assign ovf_evt = pwm ? wrap :
		(timer_tick & ~cnt_wr & (count_value_reg == `MAX_VAL));

	// read data at setup; count and capture high go through staging
	always_comb begin
		rd_mux = 8'h00;
		hi_mux = temp_reg;
		case (i_paddr)
			`A_CNT_LO: begin
				rd_mux = count_value_reg[7:0];
				hi_mux = count_value_reg[15:8];
			end
			`A_CNT_HI:  rd_mux = temp_reg;
			`A_CMPA_LO: rd_mux = cmp_buf_reg[0][7:0];
			`A_CMPA_HI: rd_mux = cmp_buf_reg[0][15:8];
			`A_CMPB_LO: rd_mux = cmp_buf_reg[1][7:0];
			`A_CMPB_HI: rd_mux = cmp_buf_reg[1][15:8];
			`A_CAP_LO: begin
				rd_mux = capture_value_reg[7:0];
				hi_mux = capture_value_reg[15:8];
			end
			`A_CAP_HI:  rd_mux = temp_reg;
			`A_CTRL_A:  rd_mux = timer_control_a_reg;
			`A_CTRL_B:  rd_mux = timer_control_b_reg;
			`A_FLAG:    rd_mux = {4'h0, timer_flag_register_reg};
			`A_MASK:    rd_mux = {4'h0, timer_mask_register_reg};
			`A_PWR:     rd_mux = {7'h00, pwr_reg};
			default:    rd_mux = 8'h00;
		endcase
	end

	// apb answer: one wait-free access cycle after every setup
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_pready    <= 1'b0;
			o_prdata    <= 32'h0000_0000;
			o_pslverr   <= 1'b0;
			snap_hi_reg <= 8'h00;
		end else begin
			o_pready  <= setup;
			o_pslverr <= setup & ~mapped(i_paddr);
			if (setup) begin
				o_prdata    <= {24'h00_0000, rd_mux};
				snap_hi_reg <= hi_mux;
			end
		end
	end

	// staging register; snapshot keeps both bytes from one cycle
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn)
			temp_reg <= 8'h00;
		else if (wr & is_hi(i_paddr))
			temp_reg <= i_pwdata[7:0];
		else if (rd & ((i_paddr == `A_CNT_LO) || (i_paddr == `A_CAP_LO)))
			temp_reg <= snap_hi_reg;
	end

	// control, mask and power bits are plain byte registers
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			timer_control_a_reg     <= `CTRL_RST;
			timer_control_b_reg     <= `CTRL_RST;
			timer_mask_register_reg <= 4'h0;
			pwr_reg                 <= `PWR_RST;
		end else if (wr) begin
			case (i_paddr)
				`A_CTRL_A: timer_control_a_reg <= i_pwdata[7:0];
				`A_CTRL_B: timer_control_b_reg <= i_pwdata[7:0];
				`A_MASK:   timer_mask_register_reg <= i_pwdata[3:0];
				`A_PWR:    pwr_reg <= i_pwdata[0];
				default:   ;
			endcase
		end
	end

	// free-running prescaler and pin synchronisers
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			psc_reg    <= '0;
			ext_s1_reg <= 1'b0;
			ext_s2_reg <= 1'b0;
			ext_d_reg  <= 1'b0;
			cap_s1_reg <= 1'b0;
			cap_s2_reg <= 1'b0;
			ac_s1_reg  <= 1'b0;
			ac_s2_reg  <= 1'b0;
		end else begin
			psc_reg    <= psc_reg + 1'b1;
			ext_s1_reg <= i_external_count_pin;
			ext_s2_reg <= ext_s1_reg;
			ext_d_reg  <= ext_s2_reg;
			cap_s1_reg <= i_capture_pin;
			cap_s2_reg <= cap_s1_reg;
			ac_s1_reg  <= i_acomp_out;
			ac_s2_reg  <= ac_s1_reg;
		end
	end

	// clock select; a held power-reduction bit freezes the tick
	always_comb begin
		case (cs)
			CS_STOP:     timer_tick = 1'b0;
			CS_DIV1:     timer_tick = 1'b1;
			CS_DIV8:     timer_tick = &psc_reg[`TAP8_W-1:0];
			CS_DIV64:    timer_tick = &psc_reg[`TAP64_W-1:0];
			CS_DIV256:   timer_tick = &psc_reg[`TAP256_W-1:0];
			CS_DIV1024:  timer_tick = &psc_reg[`TAP1024_W-1:0];
			CS_EXT_FALL: timer_tick = ~ext_s2_reg & ext_d_reg;
			CS_EXT_RISE: timer_tick = ext_s2_reg & ~ext_d_reg;
			default:     timer_tick = 1'b0;
		endcase
		timer_tick = timer_tick & ~pwr_reg;
	end

	// capture trigger: source select, filter, edge select
	assign trig = timer_control_a_reg[`CAP_SRC_BIT] ? ac_s2_reg :
		cap_s2_reg;
	assign cap_evt = ~pwr_reg & ~cap_top &
		(timer_control_b_reg[`CAP_EDG_BIT] ? (filt_reg & ~filt_d_reg) :
		(~filt_reg & filt_d_reg));

	// filter moves only on a run of equal samples; costs latency
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			hist_reg   <= '0;
			filt_reg   <= 1'b0;
			filt_d_reg <= 1'b0;
		end else begin
			hist_reg   <= {hist_reg[FILT_LEN-2:0], trig};
			filt_d_reg <= filt_reg;
			if (!timer_control_b_reg[`CAP_FLT_BIT])
				filt_reg <= trig;
			else if (&hist_reg)
				filt_reg <= 1'b1;
			else if (~|hist_reg)
				filt_reg <= 1'b0;
		end
	end

	// capture register; software may write it only while it is top
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn)
			capture_value_reg <= 16'h0000;
		else if (cap_evt)
			capture_value_reg <= count_value_reg;
		else if (cap_top & wr & (i_paddr == `A_CAP_LO))
			capture_value_reg <= wdata16;
	end

	// counter: software write first, then wrap at top or count
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn)
			count_value_reg <= `BOTTOM_VAL;
		else if (cnt_wr)
			count_value_reg <= wdata16;
		else if (wrap)
			count_value_reg <= `BOTTOM_VAL;
		else if (timer_tick)
			count_value_reg <= count_value_reg + 16'h0001;
	end

	// compare channels; pwm modes reload the buffer at top
	for (genvar c = 0; c < 2; c++) begin : g_ch
		logic [1:0] com;
		assign com = c == 0 ? timer_control_a_reg[`COMA_LSB +: 2] :
			timer_control_a_reg[`COMB_LSB +: 2];
		assign match[c]   = (count_value_reg == cmp_act_reg[c]);
		assign cmp_evt[c] = timer_tick & ~cnt_wr & match[c];

		always_ff @(posedge i_clk or negedge i_rstn) begin
			if (!i_rstn) begin
				cmp_buf_reg[c] <= 16'h0000;
				cmp_act_reg[c] <= 16'h0000;
			end else begin
				if (wr & (i_paddr == (c == 0 ? `A_CMPA_LO : `A_CMPB_LO)))
					cmp_buf_reg[c] <= wdata16;
				if (!pwm || wrap)
					cmp_act_reg[c] <= cmp_buf_reg[c];
			end
		end

		// waveform: toggle/clear/set on match, pwm drives the opposite level at top
		always_ff @(posedge i_clk or negedge i_rstn) begin
			if (!i_rstn)
				cmp_out_reg[c] <= 1'b0;
			else if (pwm && c == 0 && a_top)
				cmp_out_reg[c] <= 1'b0;
			else if (pwm && wrap && com[1])
				cmp_out_reg[c] <= ~com[0];
			else if (cmp_evt[c]) begin
				case (com)
					2'h1: cmp_out_reg[c] <= ~cmp_out_reg[c];
					2'h2: cmp_out_reg[c] <= 1'b0;
					2'h3: cmp_out_reg[c] <= 1'b1;
					default: cmp_out_reg[c] <= cmp_out_reg[c];
				endcase
			end
		end
	end

	// flags: write one clears, a same-cycle event wins
	assign flag_set = {cap_evt, cmp_evt[1], cmp_evt[0], ovf_evt};
	assign flag_clr = (wr & (i_paddr == `A_FLAG)) ? i_pwdata[3:0] : 4'h0;
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			timer_flag_register_reg <= 4'h0;
			o_int_req               <= 4'h0;
		end else begin
			timer_flag_register_reg <=
				(timer_flag_register_reg & ~flag_clr) | flag_set;
			o_int_req <= timer_flag_register_reg &
				timer_mask_register_reg;
		end
	end

	assign o_compare_a_output = cmp_out_reg[0];
	assign o_compare_b_output = cmp_out_reg[1];

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rstn);

	a_hi_write_stage: assert property (
		wr && is_hi(i_paddr) |=> temp_reg == $past(i_pwdata[7:0]))
		else $error("high byte not staged");
	a_lo_write_load: assert property (
		cnt_wr |=> count_value_reg == $past(wdata16))
		else $error("count low write did not load both bytes");
	a_lo_read_copy: assert property (
		setup && i_paddr == `A_CNT_LO ##1 rd && !i_pwrite
		|=> temp_reg == $past(count_value_reg[15:8], 2) ||
		$past(cnt_wr, 2))
		else $error("low read did not stage high byte");
	a_cmp_read_direct: assert property (
		rd && (i_paddr == `A_CMPA_HI || i_paddr == `A_CMPB_HI)
		|=> $stable(temp_reg))
		else $error("compare read disturbed staging");
	a_stop_holds: assert property (
		cs == CS_STOP && !cnt_wr |=> $stable(count_value_reg))
		else $error("counter moved with no clock source");
	a_capture_flag: assert property (
		cap_evt |=> capture_value_reg == $past(count_value_reg) &&
		timer_flag_register_reg[`F_CAP])
		else $error("capture copy and flag not together");
	a_top_wrap: assert property (
		timer_tick && !cnt_wr && at_top |=> count_value_reg == `BOTTOM_VAL)
		else $error("counter did not wrap at top");
	a_cmp_flag_set: assert property (
		cmp_evt[0] |=> timer_flag_register_reg[`F_CMPA])
		else $error("compare a match did not set flag");
	a_write_priority: assert property (
		cnt_wr && timer_tick |=> count_value_reg == $past(wdata16))
		else $error("count write lost to counting");
	a_ctrl_plain: assert property (
		wr && i_paddr == `A_CTRL_B ##1 !wr [*2]
		|-> timer_control_b_reg == $past(i_pwdata[7:0], 2))
		else $error("control b did not keep written byte");

endmodule

// file: tb/cpu_bus.sv
// processor-side bus model issuing byte transfers to the timer
module cpu_bus (
	input  wire logic        i_clk,     // system clock
	input  wire logic        i_pready,  // slave ready
	output logic             o_psel,    // select
	output logic             o_penable, // access phase
	output logic             o_pwrite,  // direction
	output logic [7:0]       o_paddr,   // byte address
	output logic [31:0]      o_pwdata,  // write data
	output logic [3:0]       o_pstrb    // byte strobes
);
	timeunit 1ns;
	timeprecision 1ps;
	// bus idle at time zero
	initial begin
		o_psel = 1'b0;
		o_penable = 1'b0;
		o_pwrite = 1'b0;
		o_paddr = 8'h00;
		o_pwdata = 32'h0;
		o_pstrb = 4'h0;
	end
	// strictly one transfer at a time, in caller order
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		o_psel <= 1'b1;
		o_penable <= 1'b0;
		o_pwrite <= w;
		o_paddr <= a;
		o_pwdata <= d;
		o_pstrb <= 4'hF;
		@(posedge i_clk);
		o_penable <= 1'b1;
		do @(posedge i_clk); while (i_pready !== 1'b1);
		// released lines carry garbage so stale data is never reused
		o_psel <= 1'b0;
		o_penable <= 1'b0;
		o_paddr <= ~a;
		o_pwdata <= ~d;
		@(posedge i_clk);
	endtask
endmodule

// file: tb/timer16_core_byte_access_bench.sv
// self-checking bench for the byte-access 16-bit timer
`include "timer16_defs.svh"
module timer16_core_byte_access_bench
	import timer16_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {
		logic        e;
		logic [31:0] d;
		logic [31:0] m;
	} note_s;
	logic        i_clk, i_rstn, psel, penable, pwrite, pready, pslverr;
	logic        ext, cap, acmp, out_a, out_b;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0]  pstrb, irq;
	logic [15:0] v, w;
	note_s       q[$];
	note_s       n;
	int          fails, n_tests, a_hi, b_hi, b_lo;

	timer16_core i_timer16_core (.i_clk(i_clk), .i_rstn(i_rstn),
		.i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
		.i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb),
		.o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr),
		.i_external_count_pin(ext), .i_capture_pin(cap),
		.i_acomp_out(acmp), .o_compare_a_output(out_a),
		.o_compare_b_output(out_b), .o_int_req(irq));
	cpu_bus i_cpu_bus (.i_clk(i_clk), .i_pready(pready), .o_psel(psel),
		.o_penable(penable), .o_pwrite(pwrite), .o_paddr(paddr),
		.o_pwdata(pwdata), .o_pstrb(pstrb));

	task automatic check(input logic [31:0] s, input logic [31:0] x,
		input string msg);
		n_tests++;
		if (s !== x) begin
			fails++;
			$display("ERROR %0t: %s seen %h expected %h", $time, msg, s, x);
		end
	endtask
	// note the expected answer, then let the processor model move it
	task automatic rw(input logic wr_n, input logic [7:0] a,
		input logic [7:0] d, input logic [7:0] m, input logic e);
		q.push_back('{e, {24'h0, d}, {24'hFFFFFF, m}});
		i_cpu_bus.xfer(wr_n, a, {24'h0, d});
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		rw(1'b1, a, d, 8'h00, 1'b0);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] d,
		input logic [7:0] m = 8'hFF);
		rw(1'b0, a, d, m, 1'b0);
	endtask
	task automatic wr16(input logic [7:0] a, input logic [15:0] d);
		wr(a + 8'h04, d[15:8]);
		wr(a, d[7:0]);
	endtask
	task automatic rd16(input logic [7:0] a, input logic [15:0] d,
		input logic [15:0] m = 16'hFFFF);
		rd(a, d[7:0], m[7:0]);
		rd(a + 8'h04, d[15:8], m[15:8]);
	endtask
	task automatic done(input string s);
		$display("test %s finished", s);
	endtask
	task automatic print_verdict;
		$display("%0d comparisons, %0d mismatches", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// clock, 25 ns period
	initial begin
		i_clk = 1'b0;
		forever #12.5 i_clk = ~i_clk;
	end
	// watchdog well beyond the expected run length
	initial begin
		repeat (20000) @(posedge i_clk);
		fails++;
		print_verdict;
	end
	// completed transfers are matched against the oldest note
	always @(posedge i_clk) begin
		if (psel && penable && pready === 1'b1) begin
			n = q.pop_front();
			check({31'h0, pslverr}, {31'h0, n.e}, "error response");
			if (!pwrite)
				check(prdata & n.m, n.d, "read data");
		end
	end

	initial begin
		void'($urandom(32'h7774789D));
		i_rstn = 1'b0;
		ext = 1'b0;
		cap = 1'b0;
		acmp = 1'b0;
		repeat (5) @(posedge i_clk);
		i_rstn <= 1'b1;
		@(posedge i_clk);
		check({26'h0, out_a, out_b, irq}, 32'h0, "reset outputs");
		rd(`A_PWR, 8'h01);
		rd(`A_CTRL_A, `CTRL_RST);
		rd(`A_CTRL_B, `CTRL_RST);
		rw(1'b0, 8'h34, 8'h00, 8'hFF, 1'b1);
		wr(`A_PWR, 8'h00);
		done("reset");
		v = 16'($urandom()) & 16'h7FFF;
		wr16(`A_CNT_LO, v);
		rd16(`A_CNT_LO, v);
		repeat (20) @(posedge i_clk);
		rd16(`A_CNT_LO, v);
		done("staging");
		// one staged byte serves a different register
		wr(`A_CMPA_HI, 8'h40);
		wr(`A_CMPB_LO, 8'h55);
		wr16(`A_CMPA_LO, 16'hFFF8);
		rd16(`A_CMPB_LO, 16'h4055);
		rd(`A_CNT_LO, v[7:0]);
		rd(`A_CMPA_HI, 8'hFF);
		rd(`A_CNT_HI, v[15:8]);
		done("shared");
		v[7:0] = 8'($urandom());
		wr(`A_CTRL_A, v[7:0]);
		rd(`A_CTRL_A, v[7:0]);
		wr(`A_CTRL_A, 8'h00);
		wr(`A_CTRL_B, 8'hC0);
		rd(`A_CTRL_B, 8'hC0);
		done("control");
		// capture with counter frozen so the stored value is exact
		w = 16'($urandom());
		wr16(`A_CNT_LO, w);
		wr(`A_FLAG, 8'h0F);
		wr(`A_MASK, 8'h08);
		cap <= 1'b1;
		repeat (2) @(posedge i_clk);
		cap <= 1'b0;
		repeat (12) @(posedge i_clk);
		rd(`A_FLAG, 8'h00);
		cap <= 1'b1;
		repeat (12) @(posedge i_clk);
		rd(`A_FLAG, 8'h08);
		check({28'h0, irq}, 32'h8, "masked request");
		rd16(`A_CAP_LO, w);
		wr(`A_CTRL_A, 8'h04);
		wr16(`A_CNT_LO, ~w);
		acmp <= 1'b1;
		repeat (12) @(posedge i_clk);
		rd16(`A_CAP_LO, ~w);
		wr(`A_CTRL_A, 8'h00);
		cap <= 1'b0;
		done("capture");
		wr16(`A_CNT_LO, w);
		wr(`A_CTRL_B, 8'h07);
		repeat (5) begin
			ext <= 1'b1;
			repeat (4) @(posedge i_clk);
			ext <= 1'b0;
			repeat (4) @(posedge i_clk);
		end
		repeat (4) @(posedge i_clk);
		wr(`A_CTRL_B, 8'h00);
		rd16(`A_CNT_LO, w + 16'h0005);
		done("external clock");
		// divide by 8: about 83 cycles give 10 or 11 ticks
		wr16(`A_CNT_LO, 16'h0000);
		wr(`A_CTRL_B, 8'h02);
		repeat (80) @(posedge i_clk);
		wr(`A_CTRL_B, 8'h00);
		rd16(`A_CNT_LO, 16'h0008, 16'hFFF8);
		done("prescaler");
		wr(`A_FLAG, 8'h0F);
		wr(`A_MASK, 8'h03);
		wr16(`A_CNT_LO, 16'hFFF0);
		wr(`A_CTRL_B, 8'h01);
		repeat (40) @(posedge i_clk);
		check({28'h0, irq}, 32'h3, "masked request");
		wr16(`A_CNT_LO, 16'h1200);
		wr(`A_CTRL_B, 8'h00);
		rd(`A_FLAG, 8'h03, 8'h07);
		rd16(`A_CNT_LO, 16'h1200, 16'hFF00);
		done("normal count");
		wr(`A_FLAG, 8'h0F);
		wr16(`A_CNT_LO, 16'h0000);
		wr(`A_CTRL_A, 8'h01);
		wr(`A_CTRL_B, 8'h01);
		repeat (600) @(posedge i_clk);
		wr(`A_CTRL_B, 8'h00);
		rd16(`A_CNT_LO, 16'h0000, 16'hFF00);
		rd(`A_FLAG, 8'h01, 8'h01);
		done("fixed top");
		// compare a as top in a pwm mode, compare b pwm
		wr(`A_CTRL_A, 8'h00);
		wr16(`A_CMPA_LO, 16'h0010);
		wr16(`A_CMPB_LO, 16'h0008);
		wr16(`A_CNT_LO, 16'h0000);
		wr(`A_CTRL_A, 8'hA3);
		wr(`A_CTRL_B, 8'h19);
		a_hi = 0;
		b_hi = 0;
		b_lo = 0;
		repeat (80) begin
			@(posedge i_clk);
			a_hi += int'(out_a !== 1'b0);
			b_hi += int'(out_b === 1'b1);
			b_lo += int'(out_b === 1'b0);
		end
		wr(`A_CTRL_B, 8'h18);
		check(32'(a_hi), 32'h0, "output a in top mode");
		check({31'h0, b_hi > 0 && b_lo > 0}, 32'h1, "pwm b");
		rd16(`A_CNT_LO, 16'h0000, 16'hFFE0);
		rd(`A_FLAG, 8'h06, 8'h06);
		// a lower top written past the count waits for the wrap
		wr16(`A_CNT_LO, 16'h0008);
		wr16(`A_CMPA_LO, 16'h0004);
		wr(`A_CTRL_B, 8'h19);
		repeat (80) @(posedge i_clk);
		wr(`A_CTRL_B, 8'h18);
		rd16(`A_CNT_LO, 16'h0000, 16'hFFF8);
		done("compare top");
		print_verdict;
	end
endmodule
